//--- common/csra_defs.svh
// Register offsets, field positions, reset values and defaults
`ifndef CSRA_DEFS_SVH
`define CSRA_DEFS_SVH

// Chip-level register indices
`define CSRA_IDX_UNIT_SELECT 8'h07
`define CSRA_IDX_BASE_LOW 8'h26
`define CSRA_IDX_BASE_HIGH 8'h27
`define CSRA_IDX_RSVD_A 8'h28
`define CSRA_IDX_RSVD_VENDOR 8'h29
`define CSRA_IDX_TEST_SIX 8'h2A
`define CSRA_IDX_TEST_FOUR 8'h2B
`define CSRA_IDX_TEST_KBC 8'h2C
`define CSRA_IDX_TEST_ONE 8'h2D
`define CSRA_IDX_TEST_TWO 8'h2E
`define CSRA_IDX_TEST_THREE 8'h2F

// Per-unit register indices
`define CSRA_IDX_UNIT_FIRST 8'h30
`define CSRA_IDX_ACTIVATE 8'h30

// Field positions
`define CSRA_ACTIVATE_BIT 0
`define CSRA_KBC_RESET_BIT 6
`define CSRA_ADDR_BIT_ZERO 0

// Reset values
`define CSRA_RST_BYTE 8'h00
`define CSRA_RST_BASE_HIGH 8'h00
`define CSRA_RST_TEST 8'h00
`define CSRA_RST_ACTIVATE 8'h00
`define CSRA_RST_UNIT_SELECT 8'h00
`define CSRA_RST_INDEX 8'h00

// Strap-selected default configuration bases
`define CSRA_DEFAULT_BASE_STRAP0 16'h002E
`define CSRA_DEFAULT_BASE_STRAP1 16'h004E

// Number of per-unit register banks
`define CSRA_UNIT_COUNT 9

`endif

//--- common/csra_pkg.sv
// Types shared by the configuration register bank
package csra_pkg;

   typedef logic [7:0] csra_byte_t;
   typedef logic [15:0] csra_addr_t;

   // Which configuration port an I/O cycle hits
   typedef enum logic [2:0] {
      CSRA_HIT_NONE = 3'b001,
      CSRA_HIT_INDEX = 3'b010,
      CSRA_HIT_DATA = 3'b100
   } csra_hit_t;

endpackage

//--- rtl/csra_unit_slot.sv
// One logical unit's enable bit shared by activate and power control
`timescale 1ns/100ps
`default_nettype none
module csra_unit_slot (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clear,
   input wire logic act_wr,
   input wire logic act_val,
   input wire logic pwr_wr,
   input wire logic pwr_val,
   output logic unit_on
);

   // Either write path drives the single shared bit, so both always agree
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         unit_on <= 1'b0;
      end else if (clear) begin
         unit_on <= 1'b0;
      end else if (act_wr) begin
         unit_on <= act_val;
      end else if (pwr_wr) begin
         unit_on <= pwr_val;
      end
   end

endmodule
`default_nettype wire

//--- rtl/csra_config_bank.sv
// Relocatable configuration port, chip test registers and unit activate
`timescale 1ns/100ps
`default_nettype none
`include "csra_defs.svh"

module csra_config_bank #(
   parameter int UNIT_COUNT = `CSRA_UNIT_COUNT
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic standby_por,
   input wire logic host_bus_reset,
   input wire logic soft_reset,
   input wire logic base_strap,
   input wire logic config_state,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rd_ack,
   input wire logic [UNIT_COUNT-1:0] unit_pwr_wr,
   input wire logic [UNIT_COUNT-1:0] unit_pwr_val,
   output logic [UNIT_COUNT-1:0] unit_active,
   output logic kbc_reset,
   output logic [15:0] config_base
);

   csra_pkg::csra_byte_t index_reg;
   csra_pkg::csra_byte_t unit_select;
   csra_pkg::csra_byte_t base_low;
   csra_pkg::csra_byte_t config_base_high_reg;
   csra_pkg::csra_byte_t test_six;
   csra_pkg::csra_byte_t test_four;
   csra_pkg::csra_byte_t test_kbc;
   csra_pkg::csra_byte_t test_one;
   csra_pkg::csra_byte_t test_two;
   csra_pkg::csra_byte_t test_three;
   csra_pkg::csra_addr_t active_base;
   csra_pkg::csra_addr_t strap_base;
   csra_pkg::csra_addr_t data_port_addr;
   csra_pkg::csra_hit_t hit;
   csra_pkg::csra_byte_t next_rdata;
   logic load_default;
   logic index_wr;
   logic data_wr;
   logic data_rd;
   logic unit_valid;
   logic unit_clear;
   logic [UNIT_COUNT-1:0] act_wr;

   // Default base chosen by the strap level
   assign strap_base = base_strap ? `CSRA_DEFAULT_BASE_STRAP1
                                  : `CSRA_DEFAULT_BASE_STRAP0;

   // Index at the base, data at the next address, both from one base
   assign data_port_addr = csra_pkg::csra_addr_t'(active_base + 16'h0001);

   // Port decode; nothing answers outside the configuration state
   always_comb begin
      hit = csra_pkg::CSRA_HIT_NONE;
      if (config_state) begin
         if (io_addr == active_base) begin
            hit = csra_pkg::CSRA_HIT_INDEX;
         end else if (io_addr == data_port_addr) begin
            hit = csra_pkg::CSRA_HIT_DATA;
         end
      end
   end

   assign index_wr = io_wr && (hit == csra_pkg::CSRA_HIT_INDEX);
   assign data_wr = io_wr && (hit == csra_pkg::CSRA_HIT_DATA);
   assign data_rd = io_rd && (hit == csra_pkg::CSRA_HIT_DATA);

   // Selected bank exists only for the nine implemented units
   assign unit_valid = (unit_select < 8'(UNIT_COUNT));

   // Standby, host bus and soft resets all clear the unit enables
   assign unit_clear = standby_por || host_bus_reset || soft_reset;

   // Strap is caught on the first edge after main reset release
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         load_default <= 1'b1;
      end else begin
         load_default <= 1'b0;
      end
   end

   // Index register written through the index port
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         index_reg <= `CSRA_RST_INDEX;
      end else if (unit_clear) begin
         index_reg <= `CSRA_RST_INDEX;
      end else if (index_wr) begin
         index_reg <= io_wdata;
      end
   end

   // Unit select register picks the visible per-unit bank
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         unit_select <= `CSRA_RST_UNIT_SELECT;
      end else if (unit_clear) begin
         unit_select <= `CSRA_RST_UNIT_SELECT;
      end else if (data_wr && index_reg == `CSRA_IDX_UNIT_SELECT) begin
         unit_select <= io_wdata;
      end
   end

   // Base bytes: only main reset and host bus reset restore the default
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         base_low <= `CSRA_RST_BYTE;
         config_base_high_reg <= `CSRA_RST_BASE_HIGH;
      end else if (load_default || host_bus_reset) begin
         base_low <= strap_base[7:0];
         config_base_high_reg <= `CSRA_RST_BASE_HIGH;
      end else if (data_wr) begin
         if (index_reg == `CSRA_IDX_BASE_LOW) begin
            // Address bit zero is forced low
            base_low <= {io_wdata[7:1], 1'b0};
         end
         if (index_reg == `CSRA_IDX_BASE_HIGH) begin
            config_base_high_reg <= io_wdata;
         end
      end
   end

   // Decoded base moves only on a high byte write, a host bus reset or the default load
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         active_base <= {`CSRA_RST_BASE_HIGH, `CSRA_RST_BYTE};
      end else if (load_default || host_bus_reset) begin
         active_base <= strap_base;
      end else if (data_wr && index_reg == `CSRA_IDX_BASE_HIGH) begin
         active_base <= {io_wdata, base_low};
      end
   end

   assign config_base = active_base;

   // Factory test registers, cleared by main and standby power-on
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         test_six <= `CSRA_RST_TEST;
         test_four <= `CSRA_RST_TEST;
         test_kbc <= `CSRA_RST_TEST;
         test_one <= `CSRA_RST_TEST;
         test_two <= `CSRA_RST_TEST;
         test_three <= `CSRA_RST_TEST;
      end else if (standby_por) begin
         test_six <= `CSRA_RST_TEST;
         test_four <= `CSRA_RST_TEST;
         test_kbc <= `CSRA_RST_TEST;
         test_one <= `CSRA_RST_TEST;
         test_two <= `CSRA_RST_TEST;
         test_three <= `CSRA_RST_TEST;
      end else if (data_wr) begin
         unique case (index_reg)
            `CSRA_IDX_TEST_SIX: begin
               test_six <= io_wdata;
            end
            `CSRA_IDX_TEST_FOUR: begin
               test_four <= io_wdata;
            end
            `CSRA_IDX_TEST_KBC: begin
               test_kbc <= io_wdata;
            end
            `CSRA_IDX_TEST_ONE: begin
               test_one <= io_wdata;
            end
            `CSRA_IDX_TEST_TWO: begin
               test_two <= io_wdata;
            end
            `CSRA_IDX_TEST_THREE: begin
               test_three <= io_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // Keyboard controller held in reset while the bit is set
   assign kbc_reset = test_kbc[`CSRA_KBC_RESET_BIT];

   // Activate write reaches only the selected unit's slot
   always_comb begin
      act_wr = '0;
      if (data_wr && unit_valid && index_reg == `CSRA_IDX_ACTIVATE) begin
         act_wr[unit_select[3:0]] = 1'b1;
      end
   end

   // One shared enable bit per unit
   genvar u;
   generate
      for (u = 0; u < UNIT_COUNT; u++) begin : g_unit
         csra_unit_slot slot (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .clear(unit_clear),
            .act_wr(act_wr[u]),
            .act_val(io_wdata[`CSRA_ACTIVATE_BIT]),
            .pwr_wr(unit_pwr_wr[u]),
            .pwr_val(unit_pwr_val[u]),
            .unit_on(unit_active[u])
         );
      end
   endgenerate

   // Read mux; reserved and unimplemented indices read zero
   always_comb begin
      next_rdata = `CSRA_RST_BYTE;
      if (hit == csra_pkg::CSRA_HIT_INDEX) begin
         next_rdata = index_reg;
      end else if (index_reg >= `CSRA_IDX_UNIT_FIRST) begin
         if (unit_valid && index_reg == `CSRA_IDX_ACTIVATE) begin
            next_rdata = {7'h00, unit_active[unit_select[3:0]]};
         end
      end else begin
         unique case (index_reg)
            `CSRA_IDX_UNIT_SELECT: begin
               next_rdata = unit_select;
            end
            `CSRA_IDX_BASE_LOW: begin
               next_rdata = base_low;
            end
            `CSRA_IDX_BASE_HIGH: begin
               next_rdata = config_base_high_reg;
            end
            `CSRA_IDX_RSVD_A, `CSRA_IDX_RSVD_VENDOR: begin
               next_rdata = `CSRA_RST_BYTE;
            end
            `CSRA_IDX_TEST_SIX: begin
               next_rdata = test_six;
            end
            `CSRA_IDX_TEST_FOUR: begin
               next_rdata = test_four;
            end
            `CSRA_IDX_TEST_KBC: begin
               next_rdata = test_kbc;
            end
            `CSRA_IDX_TEST_ONE: begin
               next_rdata = test_one;
            end
            `CSRA_IDX_TEST_TWO: begin
               next_rdata = test_two;
            end
            `CSRA_IDX_TEST_THREE: begin
               next_rdata = test_three;
            end
            default: begin
               next_rdata = `CSRA_RST_BYTE;
            end
         endcase
      end
   end

   // Read data registered, acknowledged one cycle after the request
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         io_rdata <= `CSRA_RST_BYTE;
         io_rd_ack <= 1'b0;
      end else begin
         io_rd_ack <= data_rd || (io_rd && hit == csra_pkg::CSRA_HIT_INDEX);
         if (io_rd && hit != csra_pkg::CSRA_HIT_NONE) begin
            io_rdata <= next_rdata;
         end
      end
   end

endmodule
`default_nettype wire

//--- tb/csra_checker.sv
// Port assertions for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module csra_checker #(
   parameter int UNIT_COUNT = 9
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic standby_por,
   input wire logic host_bus_reset,
   input wire logic soft_reset,
   input wire logic base_strap,
   input wire logic config_state,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rd_ack,
   input wire logic [UNIT_COUNT-1:0] unit_pwr_wr,
   input wire logic [UNIT_COUNT-1:0] unit_pwr_val,
   input wire logic [UNIT_COUNT-1:0] unit_active,
   input wire logic kbc_reset,
   input wire logic [15:0] config_base
);
   logic [7:0] idx;
   logic srst, wi, wd, rdd;
   // Decoded port hits
   assign srst = standby_por | host_bus_reset | soft_reset;
   assign wi = io_wr && config_state && io_addr == config_base;
   assign wd = io_wr && config_state && io_addr == config_base + 16'h0001;
   assign rdd = io_rd && config_state && io_addr == config_base + 16'h0001;
   // Shadow of the index register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) idx <= 8'h00;
      else if (srst) idx <= 8'h00;
      else if (wi) idx <= io_wdata;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   property p_ack;
      (rdd || (io_rd && config_state && io_addr == config_base)) && !srst
         |=> io_rd_ack;
   endproperty
   a_ack: assert property (p_ack) else $error("read not answered");
   property p_idle; !config_state |=> !io_rd_ack; endproperty
   a_idle: assert property (p_idle) else $error("ack outside state");
   property p_rsvd;
      rdd && !srst && (idx == 8'h28 || idx == 8'h29) |=> io_rdata == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
   property p_kbc;
      wd && !srst && idx == 8'h2C |=> kbc_reset == $past(io_wdata[6]);
   endproperty
   a_kbc: assert property (p_kbc) else $error("kbc reset wrong");
   property p_high;
      wd && !srst && idx == 8'h27 |=> config_base[15:8] == $past(io_wdata);
   endproperty
   a_high: assert property (p_high) else $error("base high wrong");
   property p_low; wd && !srst && idx == 8'h26 |=> $stable(config_base);
   endproperty
   a_low: assert property (p_low) else $error("low byte moved base");
   property p_home;
      host_bus_reset |=> config_base == (base_strap ? 16'h004E : 16'h002E);
   endproperty
   a_home: assert property (p_home) else $error("default base wrong");
   property p_keep;
      (standby_por || soft_reset) && !host_bus_reset |=> $stable(config_base);
   endproperty
   a_keep: assert property (p_keep) else $error("base lost");
   property p_clr; srst |=> unit_active == '0; endproperty
   a_clr: assert property (p_clr) else $error("units not cleared");
   property p_pwr;
      unit_pwr_wr[0] && !wd && !srst
         |=> unit_active[0] == $past(unit_pwr_val[0]);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power link wrong");
   c_move: cover property (wd && idx == 8'h27);
   c_kbc: cover property (kbc_reset);
   c_ack: cover property (io_rd_ack);
endmodule
bind csra_config_bank csra_checker #(.UNIT_COUNT(UNIT_COUNT)) chk_i (.clk_sys,
   .resetn, .standby_por, .host_bus_reset, .soft_reset, .base_strap,
   .config_state, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata, .io_rd_ack,
   .unit_pwr_wr, .unit_pwr_val, .unit_active, .kbc_reset, .config_base);
`default_nettype wire

//--- tb/csra_host.sv
// Host model issuing configuration I/O cycles
`timescale 1ns/100ps
`default_nettype none
module csra_host (
   input wire logic clk_sys,
   output logic io_wr,
   output logic io_rd,
   output logic [15:0] io_addr,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rd_ack
);
   // Idle bus with scrambled lines
   initial begin
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = 16'h5A5A;
      io_wdata = 8'hA5;
   end
   // One write strobe, lines inverted once released
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1 io_wr = 1'b1;
      io_addr = a;
      io_wdata = d;
      @(posedge clk_sys);
      #1 io_wr = 1'b0;
      io_addr = ~a;
      io_wdata = ~d;
   endtask
   // One read strobe, answer taken the cycle after
   task automatic rd(input logic [15:0] a, output logic [7:0] d,
      output logic k);
      @(posedge clk_sys);
      #1 io_rd = 1'b1;
      io_addr = a;
      @(posedge clk_sys);
      #1 io_rd = 1'b0;
      io_addr = ~a;
      k = io_rd_ack;
      d = io_rdata;
   endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic standby_por = 1'b0;
   logic host_bus_reset = 1'b0;
   logic soft_reset = 1'b0;
   logic base_strap = 1'b0;
   logic config_state = 1'b1;
   logic io_wr, io_rd, io_rd_ack, kbc_reset;
   logic [15:0] io_addr, config_base;
   logic [7:0] io_wdata, io_rdata;
   logic [8:0] unit_pwr_wr = 9'h000;
   logic [8:0] unit_pwr_val = 9'h000;
   logic [8:0] unit_active;
   logic [8:0] mact = 9'h000;
   logic [16:0] lf = 17'h103DF;
   int errors = 0, checked = 0, msel = 0, mbase = 16'h002E, mlo = 16'h002E;
   int mr[256];
   always #2 clk_sys = ~clk_sys;
   csra_config_bank #(.UNIT_COUNT(9)) dut (.clk_sys, .resetn, .standby_por,
      .host_bus_reset, .soft_reset, .base_strap, .config_state, .io_wr,
      .io_rd, .io_addr, .io_wdata, .io_rdata, .io_rd_ack, .unit_pwr_wr,
      .unit_pwr_val, .unit_active, .kbc_reset, .config_base);
   csra_host host (.clk_sys, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
      .io_rd_ack);
   function automatic logic [7:0] rnd();
      lf = {lf[15:0], lf[16] ^ lf[13]};
      return lf[7:0];
   endfunction
   // Model of what a data port read returns
   function automatic logic [7:0] mexp(input int i);
      if (i == 16'h0007) return 8'(msel);
      if (i == 16'h0026) return 8'(mlo);
      if (i == 16'h0027) return 8'(mbase >> 8);
      if (i == 16'h0030) return msel < 9 ? {7'h00, mact[msel]} : 8'h00;
      return (i >= 16'h002A && i <= 16'h002F) ? 8'(mr[i]) : 8'h00;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Index then data write, mirrored in the model
   task automatic w(input logic [7:0] i, input logic [7:0] d);
      host.wr(16'(mbase), i);
      host.wr(16'(mbase + 1), d);
      if (i == 8'h07) msel = d;
      if (i == 8'h26) mlo = {d[7:1], 1'b0};
      if (i == 8'h27) mbase = {d, 8'(mlo)};
      if (i == 8'h30 && msel < 9) mact[msel] = d[0];
      if (i >= 8'h2A && i <= 8'h2F) mr[i] = d;
   endtask
   task automatic r(input logic [7:0] i);
      logic [7:0] d;
      logic k;
      host.wr(16'(mbase), i);
      host.rd(16'(mbase + 1), d, k);
      chk({15'h0000, k}, 16'h0001);
      chk({8'h00, d}, {8'h00, mexp(i)});
   endtask
   // Pulse one synchronous reset kind and apply it to the model
   task automatic sr(input int n);
      {host_bus_reset, standby_por, soft_reset} = 3'(1 << n);
      @(posedge clk_sys);
      #1 {host_bus_reset, standby_por, soft_reset} = 3'h0;
      msel = 0;
      mact = 9'h000;
      if (n == 1) foreach (mr[j]) mr[j] = 0;
      if (n == 2) mbase = base_strap ? 16'h004E : 16'h002E;
      if (n == 2) mlo = mbase;
   endtask
   task automatic close_out();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100000 errors++;
      close_out();
   end
   initial begin
      logic [7:0] d;
      logic k;
      repeat (3) @(posedge clk_sys);
      #1 resetn = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk(config_base, 16'h002E);
      for (int i = 8'h28; i < 8'h30; i++) begin
         w(8'(i), rnd());
         r(8'(i));
      end
      chk({15'h0000, kbc_reset}, 16'(mr[8'h2C][6]));
      for (int u = 0; u < 10; u++) begin
         w(8'h07, 8'(u));
         w(8'h30, {7'h00, rnd() >= 8'h80});
         r(8'h30);
         chk({7'h00, unit_active}, {7'h00, mact});
      end
      unit_pwr_wr = 9'h1FF;
      unit_pwr_val = {rnd(), 1'b1};
      @(posedge clk_sys);
      #1 unit_pwr_wr = 9'h000;
      mact = unit_pwr_val;
      chk({7'h00, unit_active}, {7'h00, mact});
      w(8'h07, 8'h00);
      r(8'h30);
      config_state = 1'b0;
      host.rd(16'(mbase + 1), d, k);
      chk({15'h0000, k}, 16'h0000);
      host.wr(16'(mbase + 1), 8'h00);
      config_state = 1'b1;
      r(8'h30);
      w(8'h26, (rnd() | 8'h10) & 8'hFE);
      chk(config_base, 16'h002E);
      w(8'h27, rnd());
      chk(config_base, 16'(mbase));
      r(8'h27);
      r(8'h26);
      host.rd(16'(mbase), d, k);
      chk({7'h00, k, d}, {7'h00, 1'b1, 8'h26});
      for (int n = 0; n < 3; n++) begin
         w(8'h07, 8'h01);
         w(8'h30, 8'h01);
         if (n == 2) base_strap = 1'b1;
         sr(n);
         chk(config_base, 16'(mbase));
         chk({7'h00, unit_active}, {7'h00, mact});
         r(8'h2C);
         r(8'h26);
         chk({15'h0000, kbc_reset}, 16'(mr[8'h2C][6]));
      end
      close_out();
   end
endmodule
`default_nettype wire
